/* exp_bus_pkg.sv */
// constants shared by the expansion bus write/wait controller
// assumes one bus clock domain; all counts are bus clock periods
package exp_bus_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int CNT_W = 4;
   localparam int NUM_CS = 8;
   localparam int NUM_RDY = 4;

   // ==========================================================
   // chip select modes
   localparam logic [1:0] MODE_SPLIT = 2'h0;  // separate read/write strobes
   localparam logic [1:0] MODE_SHARED = 2'h1; // one strobe plus direction
   localparam logic [1:0] MODE_HOST = 2'h2;   // host port mode
   localparam logic [1:0] MODE_OFF = 2'h3;

   // ==========================================================
   // least settings in host port mode (phase = setting + 1)
   localparam logic [1:0] HOST_ADDR_MIN = 2'h2;
   localparam logic [1:0] HOST_SETUP_MIN = 2'h2;
   localparam logic [1:0] HOST_STROBE_MIN = 2'h1;

   // first ready line belongs to this chip select
   localparam logic [2:0] FIRST_READY_CS = 3'h4;

   // longest recovery in bus cycles
   localparam int RECOV_MAX_CYC = 17;

   // ==========================================================
   // values after reset
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [2:0] CS_RST = 3'h0;
   localparam logic [NUM_CS-1:0] CS_N_IDLE = 8'hff;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDRESS,
      PH_SETUP,
      PH_STROBE,
      PH_HOLD,
      PH_RECOVERY
   } phase_t;

endpackage

/* sync_two_stage.sv */
// two flip-flop synchroniser for pins entering the bus clock domain
// assumes inputs are asynchronous levels; first stage feeds only the second
`timescale 1ns/1ps
module sync_two_stage #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // ==========================================================
   // double register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // sync_two_stage

/* exp_bus_ctrl.sv */
// expansion bus phase sequencer with wait and ready stalls
// assumes requests come from logic on clk; wait and ready lines are pins
//
// Overview of operation
// - host address setting at least two, three clocks
// - host setup setting at least two, three clocks
// - host strobe setting at least one, two clocks
// - recovery setting sets gap between accesses
// - ready stall holds address or strobe phase
// - one more clock after stall removed
// - all counts in bus clock periods
// - address with chip select, held 11-45 cycles
// - data strobe within 4 cycles of select
// - data strobe pulse 4 to 5 cycles
// - write data valid 4-5 cycles before rise
// - write data held 4-36 cycles after rise
// - recovery between host writes at most 17
// - shared wait usable on selects 0-7
// - wait ignored for synchronous split writes
// - early wait does not hold the strobe phase
// - zero setup and strobe disable wait
// - leave strobe only when counter reaches zero
// - wait acts only in strobe phase
// - selects 4-7 use ready 0-3, programmable polarity
`timescale 1ns/1ps
module exp_bus_ctrl
(
   input wire logic clk,
   input wire logic rst_n,
   // request side
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [2:0] req_cs,
   input wire logic [exp_bus_pkg::ADDR_W-1:0] req_addr,
   input wire logic [exp_bus_pkg::DATA_W-1:0] req_wdata,
   output logic [exp_bus_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   // configuration
   input wire logic [1:0] cfg_addr_phase,
   input wire logic [1:0] cfg_setup_phase,
   input wire logic [1:0] cfg_strobe_phase,
   input wire logic [1:0] cfg_hold_phase,
   input wire logic [3:0] cfg_recovery_phase,
   input wire logic [2*exp_bus_pkg::NUM_CS-1:0] cfg_cs_mode,
   input wire logic cfg_sync_split,
   input wire logic [exp_bus_pkg::NUM_RDY-1:0] cfg_ready_pol,
   // status
   output logic busy,
   output logic [2:0] phase_now,
   // bus pins
   output logic [exp_bus_pkg::NUM_CS-1:0] cs_n,
   output logic [exp_bus_pkg::ADDR_W-1:0] bus_addr,
   output logic [exp_bus_pkg::DATA_W-1:0] bus_wdata,
   output logic bus_data_oe,
   input wire logic [exp_bus_pkg::DATA_W-1:0] bus_rdata,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic port_data_strobe_n,
   input wire logic shared_wait_n,
   input wire logic [exp_bus_pkg::NUM_RDY-1:0] per_cs_ready_lines
);

   // ==========================================================
   // declarations
   exp_bus_pkg::phase_t state, next_state;
   logic [exp_bus_pkg::CNT_W-1:0] cnt, next_cnt;
   logic [2:0] cur_cs;
   logic cur_write;
   logic cur_host;
   logic cur_wait_ok;
   logic wait_n_sync;
   logic [exp_bus_pkg::NUM_RDY-1:0] ready_sync;
   logic [exp_bus_pkg::NUM_RDY-1:0] stall_vec;
   logic port_ready_stall;
   logic stall_q;
   logic wait_eff;
   logic [1:0] req_mode;
   logic [1:0] t_addr, t_setup, t_strobe;
   logic hold_on;

   // ==========================================================
   // pin synchronisers
   sync_two_stage #(.WIDTH(1), .RST_VAL(1'b1)) u_wait_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .d(shared_wait_n),
      .q(wait_n_sync)
   );

   sync_two_stage #(.WIDTH(exp_bus_pkg::NUM_RDY), .RST_VAL(4'hf)) u_rdy_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .d(per_cs_ready_lines),
      .q(ready_sync)
   );

   // ==========================================================
   // stall decode
   // polarity bit gives the ready level
   assign stall_vec = ready_sync ^ cfg_ready_pol;
   // select 4 maps to line 0
   assign port_ready_stall = cur_host && cur_cs[2] && stall_vec[cur_cs[1:0]];
   assign hold_on = port_ready_stall || stall_q;
   // wait only counts in strobe phase
   assign wait_eff = !wait_n_sync && cur_wait_ok
                     && (state == exp_bus_pkg::PH_STROBE);

   // ==========================================================
   // setting clamps for the incoming access
   assign req_mode = cfg_cs_mode[2*req_cs +: 2];
   // address setting floor in host mode
   assign t_addr = (req_mode == exp_bus_pkg::MODE_HOST
                    && cfg_addr_phase < exp_bus_pkg::HOST_ADDR_MIN)
                   ? exp_bus_pkg::HOST_ADDR_MIN : cfg_addr_phase;
   // setup setting floor in host mode
   assign t_setup = (cur_host && cfg_setup_phase < exp_bus_pkg::HOST_SETUP_MIN)
                    ? exp_bus_pkg::HOST_SETUP_MIN : cfg_setup_phase;
   // strobe setting floor in host mode
   assign t_strobe = (cur_host && cfg_strobe_phase < exp_bus_pkg::HOST_STROBE_MIN)
                     ? exp_bus_pkg::HOST_STROBE_MIN : cfg_strobe_phase;

   // ==========================================================
   // phase sequencing; each phase lasts setting + 1 clocks
   // counter ticks once per bus clock
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         exp_bus_pkg::PH_IDLE:
         begin
            if (req_valid && req_mode != exp_bus_pkg::MODE_OFF)
            begin
               next_state = exp_bus_pkg::PH_ADDRESS;
               next_cnt = {2'h0, t_addr};
            end
         end
         exp_bus_pkg::PH_ADDRESS:
         begin
            if (cnt != exp_bus_pkg::CNT_RST)
               next_cnt = cnt - 4'h1;
            else if (!hold_on)
            begin
               next_state = exp_bus_pkg::PH_SETUP;
               next_cnt = {2'h0, t_setup};
            end
         end
         exp_bus_pkg::PH_SETUP:
         begin
            if (cnt != exp_bus_pkg::CNT_RST)
               next_cnt = cnt - 4'h1;
            else
            begin
               next_state = exp_bus_pkg::PH_STROBE;
               next_cnt = {2'h0, t_strobe};
            end
         end
         exp_bus_pkg::PH_STROBE:
         begin
            // wait holds strobe; and counter must reach zero
            if (cnt != exp_bus_pkg::CNT_RST)
               next_cnt = cnt - 4'h1;
            else if (!wait_eff && !hold_on)
            begin
               next_state = exp_bus_pkg::PH_HOLD;
               next_cnt = {2'h0, cfg_hold_phase};
            end
         end
         exp_bus_pkg::PH_HOLD:
         begin
            if (cnt != exp_bus_pkg::CNT_RST)
               next_cnt = cnt - 4'h1;
            else
            begin
               next_state = exp_bus_pkg::PH_RECOVERY;
               next_cnt = cfg_recovery_phase;
            end
         end
         exp_bus_pkg::PH_RECOVERY:
         begin
            // recovery gap; at most 16 clocks fits 17
            if (cnt != exp_bus_pkg::CNT_RST)
               next_cnt = cnt - 4'h1;
            else
               next_state = exp_bus_pkg::PH_IDLE;
         end
         default:
         begin
            next_state = exp_bus_pkg::PH_IDLE;
            next_cnt = exp_bus_pkg::CNT_RST;
         end
      endcase
   end

   // ==========================================================
   // phase register and counter
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= exp_bus_pkg::PH_IDLE;
         cnt <= exp_bus_pkg::CNT_RST;
         stall_q <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         stall_q <= port_ready_stall;
      end
   end

   // ==========================================================
   // access capture; address and data stay put until next access
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cur_cs <= exp_bus_pkg::CS_RST;
         cur_write <= 1'b0;
         cur_host <= 1'b0;
         cur_wait_ok <= 1'b0;
         bus_addr <= exp_bus_pkg::ADDR_RST;
         bus_wdata <= exp_bus_pkg::DATA_RST;
      end
      else if (state == exp_bus_pkg::PH_IDLE && next_state == exp_bus_pkg::PH_ADDRESS)
      begin
         cur_cs <= req_cs;
         cur_write <= req_write;
         cur_host <= (req_mode == exp_bus_pkg::MODE_HOST);
         // wait allowed for split and shared modes only
         cur_wait_ok <= (req_mode == exp_bus_pkg::MODE_SPLIT
                         || req_mode == exp_bus_pkg::MODE_SHARED)
                        && !(req_write && cfg_sync_split
                             && req_mode == exp_bus_pkg::MODE_SPLIT)
                        && !(cfg_setup_phase == 2'h0 && cfg_strobe_phase == 2'h0);
         bus_addr <= req_addr;
         // data stays until the next access replaces it
         bus_wdata <= req_wdata;
      end
   end

   // ==========================================================
   // pin drive, all from flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cs_n <= exp_bus_pkg::CS_N_IDLE;
         bus_data_oe <= 1'b0;
         write_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         port_data_strobe_n <= 1'b1;
      end
      else
      begin
         // select held address through hold phase
         cs_n <= exp_bus_pkg::CS_N_IDLE;
         if (next_state inside {exp_bus_pkg::PH_ADDRESS, exp_bus_pkg::PH_SETUP,
                                exp_bus_pkg::PH_STROBE, exp_bus_pkg::PH_HOLD})
            cs_n[next_state == exp_bus_pkg::PH_ADDRESS ? req_cs_sel() : cur_cs] <= 1'b0;
         bus_data_oe <= cur_write_sel() && next_state != exp_bus_pkg::PH_IDLE;
         write_strobe_n <= !(next_state == exp_bus_pkg::PH_STROBE
                             && !host_sel() && cur_write_sel());
         read_strobe_n <= !(next_state == exp_bus_pkg::PH_STROBE
                            && !host_sel() && !cur_write_sel());
         // host strobe spans setup and strobe phases
         port_data_strobe_n <= !(host_sel()
                                 && (next_state == exp_bus_pkg::PH_SETUP
                                     || next_state == exp_bus_pkg::PH_STROBE));
      end
   end

   // select the access attributes valid for the coming cycle
   function automatic logic [2:0] req_cs_sel();
      return (state == exp_bus_pkg::PH_IDLE) ? req_cs : cur_cs;
   endfunction

   function automatic logic cur_write_sel();
      return (state == exp_bus_pkg::PH_IDLE) ? req_write : cur_write;
   endfunction

   function automatic logic host_sel();
      return (state == exp_bus_pkg::PH_IDLE)
             ? (req_mode == exp_bus_pkg::MODE_HOST) : cur_host;
   endfunction

   // ==========================================================
   // read capture at the end of the strobe phase
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rd_data <= exp_bus_pkg::DATA_RST;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= 1'b0;
         if (state == exp_bus_pkg::PH_STROBE && next_state == exp_bus_pkg::PH_HOLD
             && !cur_write)
         begin
            rd_data <= bus_rdata;
            rd_valid <= 1'b1;
         end
      end
   end

   // status and handshake
   assign req_ready = (state == exp_bus_pkg::PH_IDLE);
   assign busy = (state != exp_bus_pkg::PH_IDLE);
   assign phase_now = state;

   // ==========================================================
   // checks
   // host address phase at least three clocks
   a_host_addr_len: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == exp_bus_pkg::PH_ADDRESS) && cur_host
      |-> (state == exp_bus_pkg::PH_ADDRESS) [*3])
      else $error("host address phase too short");

   // host setup phase at least three clocks
   a_host_setup_len: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == exp_bus_pkg::PH_SETUP) && cur_host
      |-> (state == exp_bus_pkg::PH_SETUP) [*3])
      else $error("host setup phase too short");

   // host strobe phase at least two clocks
   a_host_strobe_len: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == exp_bus_pkg::PH_STROBE) && cur_host
      |-> (state == exp_bus_pkg::PH_STROBE) [*2])
      else $error("host strobe phase too short");

   a_stall_holds: assert property (@(posedge clk) disable iff (!rst_n)
      state == exp_bus_pkg::PH_ADDRESS && port_ready_stall
      |=> state == exp_bus_pkg::PH_ADDRESS)
      else $error("left address phase under stall");

   // one extra clock after stall drops
   a_stall_extra: assert property (@(posedge clk) disable iff (!rst_n)
      state == exp_bus_pkg::PH_STROBE && $fell(port_ready_stall)
      |=> state == exp_bus_pkg::PH_STROBE)
      else $error("no extra clock after stall");

   // host strobe pulse lasts at least four clocks
   a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(port_data_strobe_n) |-> (!port_data_strobe_n) [*4])
      else $error("data strobe pulse too short");

   a_recov_bound: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == exp_bus_pkg::PH_RECOVERY)
      |-> ##[1:17] state != exp_bus_pkg::PH_RECOVERY)
      else $error("recovery too long");

   a_wait_holds: assert property (@(posedge clk) disable iff (!rst_n)
      wait_eff |=> state == exp_bus_pkg::PH_STROBE)
      else $error("left strobe phase under wait");

   // sync split writes ignore wait
   a_wait_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      state == exp_bus_pkg::PH_STROBE && cnt == exp_bus_pkg::CNT_RST
      && cur_write && cfg_sync_split && !cur_host && !hold_on
      && cfg_cs_mode[2*cur_cs +: 2] == exp_bus_pkg::MODE_SPLIT
      |=> state == exp_bus_pkg::PH_HOLD)
      else $error("wait not ignored for sync write");

   // strobe exits only at zero count
   a_exit_at_zero: assert property (@(posedge clk) disable iff (!rst_n)
      state == exp_bus_pkg::PH_STROBE && cnt != exp_bus_pkg::CNT_RST
      |=> state == exp_bus_pkg::PH_STROBE)
      else $error("strobe left before count done");

   // select 4 stalls on line 0
   a_ready_map: assert property (@(posedge clk) disable iff (!rst_n)
      state == exp_bus_pkg::PH_ADDRESS && cur_host && cur_cs == 3'h4
      && stall_vec[0] |=> state == exp_bus_pkg::PH_ADDRESS)
      else $error("ready line 0 ignored for select 4");

endmodule // exp_bus_ctrl

/* target_model.sv */
// wait-capable target and host-port ready source facing the bus pins
// assumes clk is the bus clock; the bench sets the stall knobs between accesses
`timescale 1ns/1ps
module target_model
(
   input wire logic clk,
   input wire logic [7:0] cs_n,
   input wire logic read_strobe_n,
   input wire logic [23:0] bus_addr,
   input wire logic [3:0] ready_pol,
   input wire logic [1:0] ready_sel,
   input wire logic [7:0] ready_start,
   input wire logic [7:0] ready_len,
   input wire logic [7:0] wait_start,
   input wire logic [7:0] wait_len,
   output logic shared_wait_n,
   output logic [3:0] per_cs_ready_lines,
   output logic [15:0] bus_rdata
);
   int age = 0;
   logic sel;
   logic [15:0] last = 16'h0000;
   // ==========================================================
   // access age
   assign sel = cs_n != 8'hff;
   // cycles since select fell; zero while nothing is selected
   always @(posedge clk)
   begin
      age <= sel ? age + 1 : 0;
   end
   // wait from the setup phase, well ahead of strobe end
   assign shared_wait_n = !(sel && wait_len != 8'h00 && age >= wait_start
                            && age < wait_start + wait_len);
   // ready taken away for a window; idle level means ready
   always_comb
   begin
      per_cs_ready_lines = ready_pol;
      if (sel && age >= ready_start && age < ready_start + ready_len)
         per_cs_ready_lines[ready_sel] = !ready_pol[ready_sel];
   end
   // released data lines toggle so a late sample never looks valid
   always @(posedge clk)
   begin
      last <= bus_rdata;
   end
   assign bus_rdata = !read_strobe_n ? (bus_addr[15:0] ^ 16'h5aa5) : ~last;
endmodule // target_model

/* tb_top.sv */
// self-checking bench for the expansion bus phase sequencer
// assumes the target model on the pins; all times in bus clock cycles
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic [2:0] req_cs = 3'h0;
   logic [23:0] req_addr = 24'h000000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0] c_a = 2'h0, c_s = 2'h0, c_t = 2'h0, c_h = 2'h0, rsel = 2'h0;
   logic [3:0] c_r = 4'h0, pol = 4'hf;
   logic sync_split = 1'b0;
   logic [7:0] ws = 8'h00, wl = 8'h00, rs = 8'h00, rl = 8'h00;
   logic req_ready, rd_valid, busy, bus_data_oe, write_strobe_n, read_strobe_n;
   logic port_data_strobe_n, shared_wait_n;
   logic [15:0] rd_data, bus_wdata, bus_rdata, data_at, rd_seen;
   logic [2:0] phase_now;
   logic [7:0] cs_n, cs_at, cs_prev = 8'hff;
   logic [23:0] bus_addr, addr_at;
   logic [3:0] per_cs_ready_lines;
   logic any_stb, stb_prev = 1'b0, oe_prev = 1'b0;
   int cyc = 0, t_cs, t_fall, t_rise, t_end, t_oe, rd_cnt, err_count = 0, check_count = 0;

   // 25 MHz bus clock
   always #20 clk = ~clk;

   exp_bus_ctrl DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_cs(req_cs), .req_addr(req_addr), .req_wdata(req_wdata),
      .rd_data(rd_data), .rd_valid(rd_valid), .cfg_addr_phase(c_a), .cfg_setup_phase(c_s),
      .cfg_strobe_phase(c_t), .cfg_hold_phase(c_h), .cfg_recovery_phase(c_r),
      .cfg_cs_mode(16'haa50), .cfg_sync_split(sync_split), .cfg_ready_pol(pol),
      .busy(busy), .phase_now(phase_now), .cs_n(cs_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_data_oe(bus_data_oe), .bus_rdata(bus_rdata),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .port_data_strobe_n(port_data_strobe_n), .shared_wait_n(shared_wait_n),
      .per_cs_ready_lines(per_cs_ready_lines));

   target_model far_end (.clk(clk), .cs_n(cs_n), .read_strobe_n(read_strobe_n),
      .bus_addr(bus_addr), .ready_pol(pol), .ready_sel(rsel), .ready_start(rs),
      .ready_len(rl), .wait_start(ws), .wait_len(wl), .shared_wait_n(shared_wait_n),
      .per_cs_ready_lines(per_cs_ready_lines), .bus_rdata(bus_rdata));

   // ==========================================================
   // pin monitor: edge times of select, strobes and data enable
   assign any_stb = !write_strobe_n || !read_strobe_n || !port_data_strobe_n;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      cs_prev <= cs_n;
      stb_prev <= any_stb;
      oe_prev <= bus_data_oe;
      if (cs_n != 8'hff && cs_prev == 8'hff) t_cs <= cyc;
      if (cs_n == 8'hff && cs_prev != 8'hff) t_end <= cyc;
      if (!any_stb && stb_prev) t_rise <= cyc;
      if (!bus_data_oe && oe_prev) t_oe <= cyc;
      if (any_stb && !stb_prev)
      begin
         t_fall <= cyc;
         cs_at <= cs_n;
         addr_at <= bus_addr;
         data_at <= bus_wdata;
      end
      if (rd_valid)
      begin
         rd_cnt <= rd_cnt + 1;
         rd_seen <= rd_data;
      end
   end

   // ==========================================================
   // tasks
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input int lo, input int hi, input int got);
      check_count++;
      if (got < lo || got > hi)
      begin
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
         err_count++;
      end
   endtask

   task automatic chk_v(input string nm, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask

   task automatic cfg(input logic [1:0] a, s, t, h, input logic [3:0] r);
      c_a = a;
      c_s = s;
      c_t = t;
      c_h = h;
      c_r = r;
   endtask

   task automatic knob(input logic [7:0] w0, w1, r0, r1, input logic [1:0] ln);
      ws = w0;
      wl = w1;
      rs = r0;
      rl = r1;
      rsel = ln;
   endtask

   // one access; holds the request until taken, then waits for idle
   task automatic access(input logic wr, input logic [2:0] cs, input logic [23:0] a);
      int n;
      n = 0;
      rd_cnt = 0;
      req_valid = 1'b1;
      req_write = wr;
      req_cs = cs;
      req_addr = a;
      req_wdata = a[15:0] ^ 16'hc3c3;
      while (!req_ready && n < 100)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      // a request that is never taken counts as a hang
      if (n >= 100) n = 400;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      chk_v("phase after accept", 24'h000001, {21'h000000, phase_now});
      while (busy && n < 400)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      chk("bounded wait", 0, 399, n);
      if (n >= 400) give_verdict();
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      int a_len, s_len, t_len, i;
      int rv[3];
      rv = '{0, 7, 15};
      a_len = exp_bus_pkg::HOST_ADDR_MIN + 1;
      s_len = exp_bus_pkg::HOST_SETUP_MIN + 1;
      t_len = exp_bus_pkg::HOST_STROBE_MIN + 1;
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // host write with zero settings clamped up to the minima
      cfg(2'h0, 2'h0, 2'h0, 2'h0, 4'h0);
      access(1'b1, 3'h4, 24'h0a5a5a);
      chk("select to strobe", a_len, a_len, t_fall - t_cs);
      chk("strobe width", s_len + t_len, s_len + t_len, t_rise - t_fall);
      chk("select length", a_len + s_len + t_len + 1, a_len + s_len + t_len + 1, t_end - t_cs);
      chk_v("select", 24'h0000ef, {16'h0000, cs_at});
      chk_v("address", 24'h0a5a5a, addr_at);
      chk_v("write data", {8'h00, 16'h5a5a ^ 16'hc3c3}, {8'h00, data_at});
      cfg(2'h0, 2'h0, 2'h0, 2'h1, 4'h2);
      access(1'b1, 3'h7, 24'h123456);
      chk("data hold", 5, 5, t_oe - t_rise);
      chk_v("select", 24'h00007f, {16'h0000, cs_at});
      $display("test host write done");
      // recovery sweep up to the widest setting
      for (i = 0; i < 3; i++)
      begin
         cfg(2'h0, 2'h0, 2'h0, 2'h0, rv[i][3:0]);
         access(1'b1, 3'h5, 24'h000100);
         // select rises as recovery starts; data enable drops as it ends
         chk("recovery length", rv[i] + 1, rv[i] + 1, t_oe - t_end);
         chk("recovery", 1, 17, t_oe - t_end);
      end
      $display("test recovery done");
      // ready stall on each line, ready level 0 on the stalled line, plus a stall on a foreign line
      for (i = 0; i < 4; i++)
      begin
         pol = i[0] ? 4'h5 : 4'ha;
         knob(8'h00, 8'h00, 8'h00, 8'h06, i[1:0]);
         access(i[0], 3'h4 + i[2:0], 24'h000200);
         chk("address stall", 8, 12, t_fall - t_cs);
         knob(8'h00, 8'h00, 8'h00, 8'h06, i[1:0] + 2'h1);
         access(1'b1, 3'h4 + i[2:0], 24'h000300);
         chk("foreign ready", a_len, a_len, t_fall - t_cs);
      end
      knob(8'h00, 8'h00, 8'h04, 8'h08, 2'h0);
      access(1'b1, 3'h4, 24'h000400);
      chk("strobe stall", 9, 15, t_rise - t_fall);
      pol = 4'hf;
      $display("test ready stall done");
      // wait on split and shared selects, reads and writes
      cfg(2'h1, 2'h1, 2'h2, 2'h0, 4'h0);
      for (i = 0; i < 4; i++)
      begin
         knob(8'h02, 8'h0a, 8'h00, 8'h00, 2'h0);
         access(i[0], i[2:0], 24'h000500 + i);
         chk("wait stretch", 8, 13, t_rise - t_fall);
         chk("read count", i[0] ? 0 : 1, i[0] ? 0 : 1, rd_cnt);
         if (!i[0]) chk_v("read data", {8'h00, 16'h0500 ^ 16'h5aa5 ^ i[15:0]}, {8'h00, rd_seen});
         knob(8'h02, 8'h02, 8'h00, 8'h00, 2'h0);
         access(1'b1, i[2:0], 24'h000600);
         chk("early release", 3, 3, t_rise - t_fall);
      end
      // synchronous split: writes ignore wait, reads still honour it
      sync_split = 1'b1;
      knob(8'h02, 8'h0a, 8'h00, 8'h00, 2'h0);
      access(1'b1, 3'h0, 24'h000700);
      chk("sync write", 3, 3, t_rise - t_fall);
      access(1'b0, 3'h0, 24'h000700);
      chk("sync read", 8, 13, t_rise - t_fall);
      sync_split = 1'b0;
      // wait gone before the strobe phase, and wait on a host select
      cfg(2'h3, 2'h1, 2'h2, 2'h0, 4'h0);
      knob(8'h00, 8'h02, 8'h00, 8'h00, 2'h0);
      access(1'b1, 3'h1, 24'h000800);
      chk("early wait", 3, 3, t_rise - t_fall);
      cfg(2'h0, 2'h0, 2'h0, 2'h0, 4'h0);
      knob(8'h02, 8'h0a, 8'h00, 8'h00, 2'h0);
      access(1'b1, 3'h6, 24'h000900);
      chk("host ignores wait", 5, 5, t_rise - t_fall);
      // zero setup and strobe turn the wait off for the access
      knob(8'h00, 8'h14, 8'h00, 8'h00, 2'h0);
      access(1'b1, 3'h1, 24'h000a00);
      chk("zero phases", 1, 1, t_rise - t_fall);
      $display("test wait done");
      give_verdict();
   end
endmodule // tb_top
